// *** vcfd_map.svh ***
`ifndef VCFD_MAP_SVH
`define VCFD_MAP_SVH
// Field identifiers
`define VCFD_ID_DEC_FLAGS  8'h06
`define VCFD_ID_COMPAND    8'h32
`define VCFD_ID_RATE_IDX   8'h09
`define VCFD_ID_RATE_CUST  8'h0A
`define VCFD_ID_INIT       8'h0B
// Argument lengths in bytes
`define VCFD_LEN_WORD      4'h2
`define VCFD_LEN_BYTE      4'h1
`define VCFD_LEN_CUST      4'hC
// Reply status bytes
`define VCFD_ST_OK         8'h00
`define VCFD_ST_ERR        8'h01
// Encoder flag bit positions
`define VCFD_EF_TONE       0
`define VCFD_EF_NS         1
`define VCFD_EF_ES         2
`define VCFD_EF_CMP_EN     3
`define VCFD_EF_CMP_ALAW   4
// Decoder flag bit positions
`define VCFD_DF_CMP_EN     0
`define VCFD_DF_CMP_ALAW   1
// Host register word offsets
`define VCFD_REG_CMD       4'h0
`define VCFD_REG_ARG0      4'h1
`define VCFD_REG_STATUS    4'h7
`define VCFD_ARG_WORDS     6
`endif

// *** vcfd_pkg.sv ***
package vcfd_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_ARG  = 3'b001,
    DEV_EXEC = 3'b010,
    DEV_RID  = 3'b011,
    DEV_RDAT = 3'b100
  } vcfd_dev_e;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_SEND = 2'b01,
    HST_RID  = 2'b10,
    HST_RDAT = 2'b11
  } vcfd_hst_e;

  typedef logic [95:0] vcfd_args_t;
endpackage : vcfd_pkg

// *** vcfd_if.sv ***
`timescale 1ns/100ps
interface vcfd_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;

  modport dev  (input h2d_data, h2d_valid, d2h_ready,
                output h2d_ready, d2h_data, d2h_valid);
  modport host (output h2d_data, h2d_valid, d2h_ready,
                input h2d_ready, d2h_data, d2h_valid);
endinterface : vcfd_if

// *** vcfd_dev.sv ***
`timescale 1ns/100ps
`include "vcfd_map.svh"
module vcfd_dev #(
  parameter int RATE_W   = 6,
  parameter int RATE_NUM = 62
) (
  // Clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 ARST_N_I,
  // Field link
  vcfd_if.dev                       LINK,
  // Configuration pins
  input  wire logic                 CFG_NS_I,
  input  wire logic                 CFG_ES_I,
  input  wire logic                 CFG_CMP_EN_I,
  input  wire logic                 CFG_CMP_ALAW_I,
  input  wire logic [RATE_W-1:0]    CFG_RATE_I,
  // Coder settings
  output logic      [15:0]          ENC_FLAGS_O,
  output logic      [15:0]          DEC_FLAGS_O,
  output logic                      CMP_EN_O,
  output logic                      CMP_ALAW_O,
  output logic      [RATE_W-1:0]    RATE_IDX_O,
  output logic                      RATE_CUSTOM_O,
  output vcfd_pkg::vcfd_args_t      RCW_O,
  // One-cycle pulses
  output logic                      RATE_LOAD_O,
  output logic                      ENC_INIT_O,
  output logic                      DEC_INIT_O,
  output logic                      EC_INIT_O
);

  localparam int PW = RATE_W + 4;

  typedef struct packed {
    vcfd_pkg::vcfd_dev_e  st;
    logic [7:0]           id;
    logic [3:0]           len;
    logic [3:0]           cnt;
    vcfd_pkg::vcfd_args_t args;
    logic [7:0]           out;
    logic [7:0]           status;
    logic [PW-1:0]        pin_a;
    logic [PW-1:0]        pin_b;
    logic [1:0]           fill;
    logic                 loaded;
    logic [15:0]          enc;
    logic [15:0]          dec;
    logic                 cmp_en;
    logic                 cmp_alaw;
    logic [RATE_W-1:0]    rate;
    logic                 custom;
    vcfd_pkg::vcfd_args_t rate_control_word;
    logic                 rate_load;
    logic                 enc_init;
    logic                 dec_init;
    logic                 ec_init;
  } vcfd_dev_s;

  vcfd_dev_s s_reg;
  vcfd_dev_s s_next;

  // ----------------------------------------------------------------
  // Field length decode
  // ----------------------------------------------------------------
  // Zero marks an identifier this block does not handle
  function automatic logic [3:0] arg_len(input logic [7:0] id);
    unique case (id)
      `VCFD_ID_DEC_FLAGS: arg_len = `VCFD_LEN_WORD;
      `VCFD_ID_COMPAND:   arg_len = `VCFD_LEN_BYTE;
      `VCFD_ID_RATE_IDX:  arg_len = `VCFD_LEN_BYTE;
      `VCFD_ID_RATE_CUST: arg_len = `VCFD_LEN_CUST;
      `VCFD_ID_INIT:      arg_len = `VCFD_LEN_BYTE;
      default:            arg_len = 4'h0;
    endcase
  endfunction : arg_len

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic             ns_pin;
  logic             es_pin;
  logic             ce_pin;
  logic             ca_pin;
  logic [RATE_W-1:0] rate_pin;
  logic [7:0]       b0;

  always_comb begin
    s_next           = s_reg;
    s_next.rate_load = 1'b0;
    s_next.enc_init  = 1'b0;
    s_next.dec_init  = 1'b0;
    s_next.ec_init   = 1'b0;
    // First stage feeds only the second stage
    s_next.pin_a = {CFG_NS_I, CFG_ES_I, CFG_CMP_EN_I, CFG_CMP_ALAW_I,
                    CFG_RATE_I};
    s_next.pin_b = s_reg.pin_a;
    {ns_pin, es_pin, ce_pin, ca_pin, rate_pin} = s_reg.pin_b;
    b0 = s_reg.args[7:0];

    // Two edges fill the synchroniser; comparing against the first stage
    // would read a flop that may still be settling, so count instead
    if (s_reg.fill != 2'h2) begin
      s_next.fill = s_reg.fill + 2'h1;
    end
    // The rate pins are caught once the synchroniser has filled
    if (!s_reg.loaded && s_reg.fill == 2'h2) begin
      s_next.loaded    = 1'b1;
      s_next.rate      = rate_pin;
      s_next.custom    = 1'b0;
      s_next.rate_load = 1'b1;
    end

    unique case (s_reg.st)
      vcfd_pkg::DEV_IDLE: begin
        if (LINK.h2d_valid && s_reg.loaded) begin
          s_next.id  = LINK.h2d_data;
          s_next.len = arg_len(LINK.h2d_data);
          s_next.cnt = 4'h0;
          if (arg_len(LINK.h2d_data) == 4'h0) begin
            // Unknown identifier: no data taken, error reply
            s_next.out    = LINK.h2d_data;
            s_next.status = `VCFD_ST_ERR;
            s_next.st     = vcfd_pkg::DEV_RID;
          end else begin
            s_next.st = vcfd_pkg::DEV_ARG;
          end
        end
      end
      vcfd_pkg::DEV_ARG: begin
        if (LINK.h2d_valid) begin
          // Shift in, so the first byte of a word lands high
          s_next.args = {s_reg.args[87:0], LINK.h2d_data};
          s_next.cnt  = s_reg.cnt + 4'h1;
          if (s_reg.cnt == s_reg.len - 4'h1) begin
            s_next.st = vcfd_pkg::DEV_EXEC;
          end
        end
      end
      vcfd_pkg::DEV_EXEC: begin
        s_next.status = `VCFD_ST_OK;
        s_next.out    = s_reg.id;
        s_next.st     = vcfd_pkg::DEV_RID;
        unique case (s_reg.id)
          `VCFD_ID_DEC_FLAGS: begin
            s_next.dec = s_reg.args[15:0];
          end
          `VCFD_ID_COMPAND: begin
            if (b0[7:2] != 6'h00) begin
              s_next.status = `VCFD_ST_ERR;
            end else begin
              s_next.cmp_en   = b0[0];
              s_next.cmp_alaw = b0[0] & b0[1];
            end
          end
          `VCFD_ID_RATE_IDX: begin
            if (b0 >= 8'(RATE_NUM)) begin
              s_next.status = `VCFD_ST_ERR;
            end else begin
              s_next.rate      = b0[RATE_W-1:0];
              s_next.custom    = 1'b0;
              s_next.rate_load = 1'b1;
            end
          end
          `VCFD_ID_RATE_CUST: begin
            s_next.rate_control_word       = s_reg.args;
            s_next.custom    = 1'b1;
            s_next.rate_load = 1'b1;
          end
          default: begin
            if (b0[7:3] != 5'h00) begin
              s_next.status = `VCFD_ST_ERR;
            end else begin
              if (b0[0]) begin
                s_next.enc                    = 16'h0000;
                s_next.enc[`VCFD_EF_TONE]     = 1'b1;
                s_next.enc[`VCFD_EF_NS]       = ns_pin;
                s_next.enc[`VCFD_EF_ES]       = es_pin | b0[2];
                s_next.enc[`VCFD_EF_CMP_EN]   = ce_pin;
                s_next.enc[`VCFD_EF_CMP_ALAW] = ca_pin;
                s_next.enc_init               = 1'b1;
              end
              if (b0[1]) begin
                s_next.dec                    = 16'h0000;
                s_next.dec[`VCFD_DF_CMP_EN]   = ce_pin;
                s_next.dec[`VCFD_DF_CMP_ALAW] = ca_pin;
                s_next.dec_init               = 1'b1;
              end
              s_next.ec_init = b0[2];
            end
          end
        endcase
      end
      vcfd_pkg::DEV_RID: begin
        if (LINK.d2h_ready) begin
          s_next.out = s_reg.status;
          s_next.st  = vcfd_pkg::DEV_RDAT;
        end
      end
      vcfd_pkg::DEV_RDAT: begin
        if (LINK.d2h_ready) begin
          s_next.st = vcfd_pkg::DEV_IDLE;
        end
      end
      default: begin
        s_next.st = vcfd_pkg::DEV_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign LINK.h2d_ready = s_reg.loaded &&
                          (s_reg.st == vcfd_pkg::DEV_IDLE ||
                           s_reg.st == vcfd_pkg::DEV_ARG);
  assign LINK.d2h_valid = s_reg.st == vcfd_pkg::DEV_RID ||
                          s_reg.st == vcfd_pkg::DEV_RDAT;
  assign LINK.d2h_data  = s_reg.out;
  assign ENC_FLAGS_O    = s_reg.enc;
  assign DEC_FLAGS_O    = s_reg.dec;
  assign CMP_EN_O       = s_reg.cmp_en;
  assign CMP_ALAW_O     = s_reg.cmp_alaw;
  assign RATE_IDX_O     = s_reg.rate;
  assign RATE_CUSTOM_O  = s_reg.custom;
  assign RCW_O          = s_reg.rate_control_word;
  assign RATE_LOAD_O    = s_reg.rate_load;
  assign ENC_INIT_O     = s_reg.enc_init;
  assign DEC_INIT_O     = s_reg.dec_init;
  assign EC_INIT_O      = s_reg.ec_init;

endmodule : vcfd_dev

// *** vcfd_host.sv ***
`timescale 1ns/100ps
`include "vcfd_map.svh"
module vcfd_host (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  // Wishbone slave
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_CYC_I,
  output logic             WB_ACK_O,
  // Field link
  vcfd_if.host             LINK
);

  typedef struct packed {
    vcfd_pkg::vcfd_hst_e  st;
    logic [7:0]           id;
    logic [3:0]           left;
    vcfd_pkg::vcfd_args_t args;
    vcfd_pkg::vcfd_args_t shift;
    logic [7:0]           out;
    logic                 ack;
    logic [31:0]          dat;
    logic                 done;
    logic                 err;
    logic [7:0]           rsp_id;
    logic [7:0]           rsp_dat;
  } vcfd_hst_s;

  vcfd_hst_s s_reg;
  vcfd_hst_s s_next;

  logic       hit;
  logic       busy;
  logic [3:0] len;
  logic [2:0] widx;

  // ----------------------------------------------------------------
  // Field length decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] arg_len(input logic [7:0] id);
    unique case (id)
      `VCFD_ID_DEC_FLAGS: arg_len = `VCFD_LEN_WORD;
      `VCFD_ID_COMPAND:   arg_len = `VCFD_LEN_BYTE;
      `VCFD_ID_RATE_IDX:  arg_len = `VCFD_LEN_BYTE;
      `VCFD_ID_RATE_CUST: arg_len = `VCFD_LEN_CUST;
      `VCFD_ID_INIT:      arg_len = `VCFD_LEN_BYTE;
      default:            arg_len = 4'h0;
    endcase
  endfunction : arg_len

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next     = s_reg;
    s_next.ack = 1'b0;
    hit        = WB_CYC_I && WB_STB_I && !s_reg.ack;
    busy       = s_reg.st != vcfd_pkg::HST_IDLE;
    len        = arg_len(WB_DAT_I[7:0]);
    widx       = 3'(WB_ADR_I - `VCFD_REG_ARG0);

    if (hit) begin
      s_next.ack = 1'b1;
      s_next.dat = 32'h0000_0000;
      if (WB_ADR_I == `VCFD_REG_STATUS) begin
        s_next.dat = {8'h00, s_reg.rsp_dat, s_reg.rsp_id, 5'h00,
                      s_reg.err, s_reg.done, busy};
      end else if (WB_ADR_I >= `VCFD_REG_ARG0 &&
                   WB_ADR_I < `VCFD_REG_STATUS) begin
        s_next.dat = {16'h0000, s_reg.args[16*(5-widx) +: 16]};
      end
      if (WB_WE_I && WB_ADR_I == `VCFD_REG_CMD && WB_SEL_I[0] &&
          !busy) begin
        s_next.done = 1'b0;
        s_next.err  = 1'b0;
        // Unknown ids still go out alone, so the far end reports the error
        s_next.id  = WB_DAT_I[7:0];
        s_next.out = WB_DAT_I[7:0];
        // Short fields send only the low end of the last word
        s_next.shift = s_reg.args << (8 * (12 - len));
        s_next.left  = len;
        s_next.st    = vcfd_pkg::HST_SEND;
      end else if (WB_WE_I && WB_ADR_I >= `VCFD_REG_ARG0 &&
                   WB_ADR_I < `VCFD_REG_STATUS && !busy) begin
        if (WB_SEL_I[1]) begin
          s_next.args[16*(5-widx)+8 +: 8] = WB_DAT_I[15:8];
        end
        if (WB_SEL_I[0]) begin
          s_next.args[16*(5-widx) +: 8] = WB_DAT_I[7:0];
        end
      end
    end

    unique case (s_reg.st)
      vcfd_pkg::HST_IDLE: begin
      end
      vcfd_pkg::HST_SEND: begin
        if (LINK.h2d_ready) begin
          s_next.out   = s_reg.shift[95:88];
          s_next.shift = {s_reg.shift[87:0], 8'h00};
          s_next.left  = s_reg.left - 4'h1;
          if (s_reg.left == 4'h0) begin
            s_next.st = vcfd_pkg::HST_RID;
          end
        end
      end
      vcfd_pkg::HST_RID: begin
        if (LINK.d2h_valid) begin
          s_next.rsp_id = LINK.d2h_data;
          s_next.st     = vcfd_pkg::HST_RDAT;
        end
      end
      vcfd_pkg::HST_RDAT: begin
        if (LINK.d2h_valid) begin
          s_next.rsp_dat = LINK.d2h_data;
          s_next.done    = 1'b1;
          s_next.err     = LINK.d2h_data != `VCFD_ST_OK ||
                           s_reg.rsp_id != s_reg.id;
          s_next.st      = vcfd_pkg::HST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign WB_ACK_O       = s_reg.ack;
  assign WB_DAT_O       = s_reg.dat;
  assign LINK.h2d_data  = s_reg.out;
  assign LINK.h2d_valid = s_reg.st == vcfd_pkg::HST_SEND;
  assign LINK.d2h_ready = s_reg.st == vcfd_pkg::HST_RID ||
                          s_reg.st == vcfd_pkg::HST_RDAT;

endmodule : vcfd_host

// *** vcfd_monitor.sv ***
`timescale 1ns/100ps
module vcfd_monitor (
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       ARST_N_I,
  // Field link
  input  wire logic [7:0] h2d_data,
  input  wire logic       h2d_valid,
  input  wire logic       h2d_ready,
  input  wire logic [7:0] d2h_data,
  input  wire logic       d2h_valid,
  input  wire logic       d2h_ready
);
  // ----
  // Field tracking
  // ----
  typedef struct packed {
    logic       busy;
    logic       rsp2;
    logic [7:0] fid;
    logic [3:0] left;
  } vcfd_mon_s;

  vcfd_mon_s mon_reg;
  vcfd_mon_s mon_next;
  logic      h_take;
  logic      d_take;

  assign h_take = h2d_valid & h2d_ready;
  assign d_take = d2h_valid & d2h_ready;

  // Unknown ids carry no argument bytes
  function automatic logic [3:0] arg_len(input logic [7:0] id);
    case (id)
      8'h06:               arg_len = 4'h2;
      8'h32, 8'h09, 8'h0B: arg_len = 4'h1;
      8'h0A:               arg_len = 4'hC;
      default:             arg_len = 4'h0;
    endcase
  endfunction : arg_len

  always_comb begin
    mon_next = mon_reg;
    if (h_take) begin
      if (!mon_reg.busy) begin
        mon_next.busy = 1'b1;
        mon_next.fid  = h2d_data;
        mon_next.left = arg_len(h2d_data);
      end else begin
        mon_next.left = mon_reg.left - 4'h1;
      end
    end
    if (d_take) begin
      mon_next.rsp2 = !mon_reg.rsp2;
      if (mon_reg.rsp2) begin
        mon_next.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mon_reg <= '0;
    end else begin
      mon_reg <= mon_next;
    end
  end

  // ----
  // Properties
  // ----
  default clocking mon_cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  reply_id_a: assert property (
    d2h_valid && !mon_reg.rsp2 |-> d2h_data == mon_reg.fid)
    else $error("reply id differs from field id");
  reply_status_a: assert property (
    d2h_valid && mon_reg.rsp2 |-> d2h_data inside {8'h00, 8'h01})
    else $error("reply status byte out of range");
  reply_gate_a: assert property (
    d2h_valid |-> mon_reg.busy && mon_reg.left == 4'h0 && !h2d_ready)
    else $error("reply before field complete");
  arg_count_a: assert property (
    mon_reg.busy && mon_reg.left == 4'h0 |-> !h2d_ready)
    else $error("byte taken beyond field length");
  reply_delay_a: assert property (
    h_take && mon_reg.busy && mon_reg.left == 4'h1
      |=> !d2h_valid ##1 d2h_valid)
    else $error("reply not two cycles after last byte");
  unknown_delay_a: assert property (
    h_take && !mon_reg.busy && arg_len(h2d_data) == 4'h0 |=> d2h_valid)
    else $error("unknown id not answered next cycle");
  reply_hold_a: assert property (
    d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("reply byte dropped before taken");
  reply_end_a: assert property (
    d_take && mon_reg.rsp2 |=> !d2h_valid)
    else $error("reply longer than two bytes");
  send_hold_a: assert property (
    h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("field byte dropped before taken");
endmodule : vcfd_monitor

// *** test_vocoder_control_field_decoder.sv ***
`timescale 1ns/100ps
module test_vocoder_control_field_decoder;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        we = 1'b0;
  logic        stb = 1'b0;
  logic [5:0]  cfg_rate = 6'h2A;
  logic [3:0]  cfg = 4'hD;
  logic [31:0] rdat, rd;
  logic        ack, cmp_en, cmp_al, custom, ld, ei, di, eci;
  logic [15:0] enc_f, dec_f, e_enc, e_dec;
  logic [5:0]  rate, e_rate;
  logic [7:0]  st, v;
  logic [95:0] e_rcw;
  vcfd_pkg::vcfd_args_t rate_control_word;
  int miscompares = 0;
  int num_checks = 0;
  int n_ld = 0, n_ei = 0, n_di = 0, n_ec = 0;
  int e_ld, e_ei, e_di, e_ec, i;
  logic [7:0]  c_opt[5] = '{8'h03, 8'h01, 8'h04, 8'h02, 8'h00};
  logic [1:0]  c_exp[5] = '{2'b11, 2'b01, 2'b01, 2'b00, 2'b00};
  logic [7:0]  r_idx[3] = '{8'h05, 8'h3E, 8'h3D};
  logic [7:0]  i_val[6] = '{8'h01, 8'h04, 8'h02, 8'h07, 8'h03, 8'h08};
  logic [15:0] w[6] = '{16'h0038, 16'h0765, 16'h0000, 16'h0000,
                        16'h0000, 16'h0038};

  always #5 clk = ~clk;

  always @(posedge clk) begin
    n_ld <= n_ld + int'(ld);
    n_ei <= n_ei + int'(ei);
    n_di <= n_di + int'(di);
    n_ec <= n_ec + int'(eci);
  end

  vcfd_if i_vcfd_if ();
  vcfd_host i_vcfd_host (.CLK_I(clk), .ARST_N_I(arst_n), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(4'hF),
    .WB_STB_I(stb), .WB_CYC_I(stb), .WB_ACK_O(ack),
    .LINK(i_vcfd_if.host));
  vcfd_dev #(.RATE_W(6), .RATE_NUM(62)) i_vcfd_dev (.CLK_I(clk),
    .ARST_N_I(arst_n), .LINK(i_vcfd_if.dev), .CFG_NS_I(cfg[0]),
    .CFG_ES_I(cfg[1]), .CFG_CMP_EN_I(cfg[2]), .CFG_CMP_ALAW_I(cfg[3]),
    .CFG_RATE_I(cfg_rate), .ENC_FLAGS_O(enc_f), .DEC_FLAGS_O(dec_f),
    .CMP_EN_O(cmp_en), .CMP_ALAW_O(cmp_al), .RATE_IDX_O(rate),
    .RATE_CUSTOM_O(custom), .RCW_O(rate_control_word), .RATE_LOAD_O(ld),
    .ENC_INIT_O(ei), .DEC_INIT_O(di), .EC_INIT_O(eci));
  vcfd_monitor i_vcfd_monitor (.CLK_I(clk), .ARST_N_I(arst_n),
    .h2d_data(i_vcfd_if.h2d_data), .h2d_valid(i_vcfd_if.h2d_valid),
    .h2d_ready(i_vcfd_if.h2d_ready), .d2h_data(i_vcfd_if.d2h_data),
    .d2h_valid(i_vcfd_if.d2h_valid), .d2h_ready(i_vcfd_if.d2h_ready));

  // ----
  // Bus and compare tasks
  // ----
  task automatic chk_out(input logic [95:0] got, input logic [95:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_out

  // Request held until ack is seen at an edge
  task automatic wb(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    we <= wr;
    adr <= a;
    wdat <= d;
    stb <= 1'b1;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    rd = rdat;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) miscompares++;
  endtask : wb

  // Sends one field and checks the reply seen in status
  task automatic field(input logic [7:0] id, input logic [15:0] arg,
                       input logic [7:0] s);
    int n;
    n = 0;
    wb(1'b1, 4'h6, {16'h0000, arg});
    wb(1'b1, 4'h0, {24'h000000, id});
    do begin
      wb(1'b0, 4'h7, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 40);
    chk_out({rd[23:8], rd[2:0]}, {s, id, s != 8'h00, 2'b10});
  endtask : field

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // ----
  // Tests
  // ----
  initial begin
    #200000;
    miscompares++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk_out({rate, n_ld}, {6'h2A, 32'd1});
    field(8'h06, 16'hA5C3, 8'h00);
    chk_out(dec_f, 16'hA5C3);
    for (i = 0; i < 5; i++) begin
      st = (|c_opt[i][7:2]) ? 8'h01 : 8'h00;
      field(8'h32, {8'h00, c_opt[i]}, st);
      chk_out({cmp_al & cmp_en, cmp_en}, c_exp[i]);
    end
    // Six words, each high byte first
    for (i = 0; i < 6; i++) begin
      wb(1'b1, 4'(i + 1), {16'h0000, w[i]});
      e_rcw = {e_rcw[79:0], w[i]};
    end
    wb(1'b0, 4'h1, 32'h0);
    chk_out(rd, {16'h0000, w[0]});
    wb(1'b0, 4'h6, 32'h0);
    chk_out(rd, {16'h0000, w[5]});
    field(8'h0A, w[5], 8'h00);
    chk_out({custom, rate_control_word, n_ld}, {1'b1, e_rcw, 32'd2});
    e_rate = 6'h2A;
    e_ld = 2;
    for (i = 0; i < 3; i++) begin
      st = (r_idx[i] >= 8'h3E) ? 8'h01 : 8'h00;
      field(8'h09, {8'h00, r_idx[i]}, st);
      if (st == 8'h00) begin
        e_rate = r_idx[i][5:0];
        e_ld++;
      end
      chk_out({custom, rate, n_ld}, {1'b0, e_rate, e_ld});
    end
    e_enc = 16'h0000;
    e_dec = 16'hA5C3;
    e_ei = 0;
    e_di = 0;
    e_ec = 0;
    for (i = 0; i < 7; i++) begin
      if (i == 6) begin
        cfg <= 4'h2;
        repeat (4) @(posedge clk);
      end
      v = (i == 6) ? 8'h03 : i_val[i];
      st = (|v[7:3]) ? 8'h01 : 8'h00;
      field(8'h0B, {8'h00, v}, st);
      if (st == 8'h00) begin
        if (v[0]) e_enc = {11'h000, cfg[3], cfg[2], cfg[1] | v[2],
                           cfg[0], 1'b1};
        if (v[1]) e_dec = {14'h0000, cfg[3], cfg[2]};
        e_ei += int'(v[0]);
        e_di += int'(v[1]);
        e_ec += int'(v[2]);
      end
      chk_out({enc_f, dec_f}, {e_enc, e_dec});
      chk_out({n_ei, n_di, n_ec}, {e_ei, e_di, e_ec});
    end
    field(8'h55, 16'h0000, 8'h01);
    final_report();
  end
endmodule : test_vocoder_control_field_decoder
